// *** pkg/cst_pkg.sv ***
package cst_pkg;
  // reference clock and timing
  localparam int CLK_MHZ        = 50;
  localparam int TICK_US        = 1000;
  localparam int TICK_CYC       = TICK_US * CLK_MHZ;
  localparam int PULSE_US       = 128;
  localparam int PULSE_CYC      = PULSE_US * CLK_MHZ;
  localparam int WD_S           = 30;
  localparam int WD_TICKS       = WD_S * 1000000 / TICK_US;
  localparam int SAFE_MIN       = 27;
  localparam int SAFE_TICKS     = SAFE_MIN * 60 * 1000000 / TICK_US;
  localparam int DETECT_MS      = 250;
  localparam int DETECT_TICKS   = DETECT_MS * 1000 / TICK_US;
  localparam int DEGLITCH_MS    = 64;
  localparam int DEGLITCH_TICKS = DEGLITCH_MS * 1000 / TICK_US;
  localparam int TW             = 24;

  // register indexes, byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h00;
  localparam logic [7:0] IDX_SUPPLY = 8'h01;
  localparam logic [7:0] IDX_CTRL   = 8'h02;
  localparam logic [7:0] IDX_VREG   = 8'h03;
  localparam logic [7:0] IDX_CHG    = 8'h04;
  localparam logic [7:0] IDX_SAFETY = 8'h05;

  // field positions
  localparam int CTRL_HIZ   = 0;
  localparam int CTRL_CE_N  = 1;
  localparam int CTRL_ILIM  = 2;
  localparam int CTRL_KICK  = 7;
  localparam int CHG_TERM   = 3;
  localparam int CHG_ICHG   = 4;
  localparam int SAFE_SEL   = 5;
  localparam int SUP_NEW    = 0;
  localparam int SUP_VALID  = 1;
  localparam int STAT_FAULT = 4;
  localparam int STAT_DM    = 7;

  // reset and default values
  localparam logic [5:0] VREG_DEF = 6'h05;
  localparam logic [3:0] ICHG_DEF = 4'h4;
  localparam logic [1:0] SEL_DEF  = 2'h0;
  localparam logic       TERM_DEF = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CHARGE = 3'b001,
    ST_SINK   = 3'b010,
    ST_SOURCE = 3'b011,
    ST_WAIT   = 3'b100,
    ST_DONE   = 3'b101
  } cst_state_t;

  typedef enum logic [1:0] {
    FLT_NONE   = 2'b00,
    FLT_OVP    = 2'b01,
    FLT_NOBAT  = 2'b10,
    FLT_SAFETY = 2'b11
  } cst_fault_t;

  // analog comparator levels and pins
  typedef struct packed {
    logic input_valid;
    logic bat_above_detect;
    logic bat_above_uvlo;
    logic bat_below_dm;
    logic bat_ovp;
    logic short_limit;
    logic term_reached;
    logic load_at_zero;
    logic ilim_pin;
  } cst_sense_t;

  typedef struct packed {
    logic converter_en;
    logic battery_switch_on;
    logic detect_sink_en;
    logic short_source_en;
    logic discharge_gate_drive;
    logic stat_int_pulse;
    logic default_mode;
    logic input_limit_high;
    logic battery_node_hiz;
  } cst_drive_t;
endpackage : cst_pkg

// *** hw/cst_charge_supervisor.sv ***
// Function
// - termination met starts battery detection
// - sink holds above threshold: present, done
// - drop below threshold: not-present fault, continue
// - failed sink: source, stop, wait, sink
// - repeat; found battery clears fault, recharges
// - no detection when termination disabled
// - new supply: pulse, normal faults, flag
// - charge enable low allows charging, write starts
// - overvoltage: converter off, switch on, report
// - battery-only short: switch off deglitch, retry
// - no input, undervoltage: switch off, hiz
// - gate drive without supply or hiz select
// - three default mode entry conditions
// - default entry reloads registers, restarts safety
// - default regulation 3.6 V, current 1 A
// - host programming exits default, pin ignored
// - terminated stays terminated entering default mode
// - safety expiry halts, sets enable bit, pulses
// - safety fault needs toggle; select change resets
// - host timeout after access, kick self-clears
// - timeout expiry enters default unless safety expired, keeps charging
// - zero charge, rising load: supplement mode
// - termination disabled by writing bit zero
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
module cst_charge_supervisor #(
  parameter int unsigned TICK_CYCLES  = cst_pkg::TICK_CYC,
  parameter int unsigned PULSE_CYCLES = cst_pkg::PULSE_CYC,
  parameter int unsigned WD_LIMIT     = cst_pkg::WD_TICKS,
  parameter int unsigned SAFE_LIMIT   = cst_pkg::SAFE_TICKS
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire cst_pkg::cst_sense_t sense,
  output cst_pkg::cst_drive_t      drive
);
  import cst_pkg::*;

  localparam int SW = $bits(cst_sense_t);

  cst_sense_t  s1, s2, s3, sn;
  cst_state_t  state, next_state;
  cst_fault_t  fault;
  logic [31:0] presc;
  logic        tick;
  logic [TW-1:0] det_cnt, glitch_cnt, wd_cnt, safe_cnt;
  logic [31:0] pulse_cnt;
  logic        acc, wr_pend;
  logic [7:0]  wr_idx;
  logic        ce_n, hiz, ilim, kick, term_en, new_supply;
  logic [5:0]  vreg;
  logic [3:0]  ichg;
  logic [1:0]  safe_sel;
  logic        host_seen, default_mode, dm_load, wd_expire;
  logic        safe_expired, safe_hit, charging, charge_allowed, charge_start;
  logic        valid_d, fault_d, fault_now, nobat_seen, short_hold;
  logic        ce_write0, sel_change, pulse_req, input_rise;
  cst_drive_t  next_drive;

  function automatic logic [TW-1:0] safe_limit(input logic [1:0] sel, input int unsigned base);
    safe_limit = TW'(base) << sel;
  endfunction

  // three-stage sync, a bit changes once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sn <= '0;
    end else begin
      s1 <= sense;
      s2 <= s1;
      s3 <= s2;
      sn <= SW'((~(s2 ^ s3) & s2) | ((s2 ^ s3) & sn));
    end
  end

  // free-running millisecond reference tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc <= 32'h0000_0000;
    end else if (presc >= 32'(TICK_CYCLES - 1)) begin
      presc <= 32'h0000_0000;
    end else begin
      presc <= presc + 32'h0000_0001;
    end
  end
  assign tick = (presc >= 32'(TICK_CYCLES - 1));

  // bus slave, zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc       = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_pend <= acc & hwrite;
      wr_idx  <= haddr[9:2];
      hrdata  <= 32'h0000_0000;
      if (acc && !hwrite && haddr[31:10] == 22'h00_0000) begin
        case (haddr[9:2])
          IDX_STATUS: hrdata <= {24'h00_0000, default_mode, 1'b0, fault, 1'b0, state};
          IDX_SUPPLY: hrdata <= {30'h0000_0000, sn.input_valid, new_supply};
          IDX_CTRL:   hrdata <= {24'h00_0000, kick, 4'h0, ilim, ce_n, hiz};
          IDX_VREG:   hrdata <= {26'h000_0000, vreg};
          IDX_CHG:    hrdata <= {24'h00_0000, ichg, term_en, 3'h0};
          IDX_SAFETY: hrdata <= {25'h000_0000, safe_sel, 5'h00};
          default:    hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign ce_write0  = wr_pend && wr_idx == IDX_CTRL && !hwdata[CTRL_CE_N];
  assign sel_change = wr_pend && wr_idx == IDX_SAFETY && hwdata[SAFE_SEL+:2] != safe_sel;

  // host registers; default-mode entry reloads them all
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ce_n     <= 1'b0;
      hiz      <= 1'b0;
      ilim     <= 1'b0;
      kick     <= 1'b0;
      vreg     <= VREG_DEF;
      ichg     <= ICHG_DEF;
      term_en  <= TERM_DEF;
      safe_sel <= SEL_DEF;
    end else if (dm_load) begin
      ce_n     <= 1'b0;
      hiz      <= 1'b0;
      ilim     <= 1'b0;
      kick     <= 1'b0;
      vreg     <= VREG_DEF;
      ichg     <= ICHG_DEF;
      term_en  <= TERM_DEF;
      safe_sel <= SEL_DEF;
    end else begin
      kick <= 1'b0;
      if (wr_pend) begin
        case (wr_idx)
          IDX_CTRL: begin
            ce_n <= hwdata[CTRL_CE_N];
            hiz  <= hwdata[CTRL_HIZ];
            ilim <= hwdata[CTRL_ILIM];
            kick <= hwdata[CTRL_KICK];
          end
          IDX_VREG:   vreg     <= hwdata[5:0];
          IDX_CHG: begin
            ichg    <= hwdata[CHG_ICHG+:4];
            term_en <= hwdata[CHG_TERM];
          end
          IDX_SAFETY: safe_sel <= hwdata[SAFE_SEL+:2];
          default:    ;
        endcase
      end
      // expiry overrides a same-cycle write of the enable bit
      if (safe_hit) begin
        ce_n <= 1'b1;
      end
    end
  end

  // new-supply flag: set wins over the write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      new_supply <= 1'b0;
    end else if (input_rise) begin
      new_supply <= 1'b1;
    end else if (wr_pend && wr_idx == IDX_SUPPLY && hwdata[SUP_NEW]) begin
      new_supply <= 1'b0;
    end
  end

  // default mode entry and exit
  assign fault_now = sn.bat_ovp | ~sn.input_valid;
  assign dm_load   = (wd_expire & ~safe_expired) |
                     (~host_seen & ~default_mode &
                      ((charge_allowed & sn.bat_below_dm) | (fault_d & ~fault_now)));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      default_mode <= 1'b1;
      host_seen    <= 1'b0;
      fault_d      <= 1'b0;
      valid_d      <= 1'b0;
    end else begin
      fault_d <= fault_now;
      valid_d <= sn.input_valid;
      if (wd_expire) begin
        host_seen <= 1'b0;
      end else if (acc) begin
        host_seen <= 1'b1;
      end
      if (dm_load) begin
        default_mode <= 1'b1;
      end else if (wr_pend) begin
        default_mode <= 1'b0;
      end
    end
  end
  assign input_rise = sn.input_valid & ~valid_d;

  // host watchdog, restarted by the first access and by the kick bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt <= '0;
    end else if (!host_seen || kick) begin
      wd_cnt <= '0;
    end else if (tick) begin
      wd_cnt <= wd_cnt + TW'(1);
    end
  end
  assign wd_expire = host_seen & ~kick & (wd_cnt >= TW'(WD_LIMIT));

  // safety timer, runs across the whole charge process
  assign charging = (state == ST_CHARGE) | (state == ST_SINK) |
                    (state == ST_SOURCE) | (state == ST_WAIT);
  assign safe_hit = charging & ~safe_expired & (safe_cnt >= safe_limit(safe_sel, SAFE_LIMIT));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      safe_cnt     <= '0;
      safe_expired <= 1'b0;
    end else begin
      if (charge_start || sel_change || dm_load) begin
        safe_cnt <= '0;
      end else if (tick && charging && safe_sel != 2'h3) begin
        safe_cnt <= safe_cnt + TW'(1);
      end
      if (safe_hit) begin
        safe_expired <= 1'b1;
      end else if (ce_write0 && ce_n) begin
        safe_expired <= 1'b0;
      end
    end
  end

  // charge process and battery detection
  assign charge_allowed = sn.input_valid & ~ce_n & ~hiz & ~sn.bat_ovp & ~safe_expired;
  assign charge_start   = (state == ST_IDLE) & charge_allowed;
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:   if (charge_allowed) next_state = ST_CHARGE;
      ST_CHARGE: if (sn.term_reached && term_en) next_state = ST_SINK;
      ST_SINK: begin
        if (!sn.bat_above_detect) begin
          next_state = ST_SOURCE;
        end else if (det_cnt >= TW'(DETECT_TICKS)) begin
          next_state = nobat_seen ? ST_CHARGE : ST_DONE;
        end
      end
      ST_SOURCE: begin
        if (sn.bat_above_detect || det_cnt >= TW'(DETECT_TICKS)) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT:   if (det_cnt >= TW'(DETECT_TICKS)) next_state = ST_SINK;
      ST_DONE:   if (ce_write0) next_state = ST_CHARGE;
      default:   next_state = ST_IDLE;
    endcase
    if (!charge_allowed || safe_hit || (state != ST_IDLE && input_rise)) begin
      next_state = ST_IDLE;
    end
    if (state == ST_DONE && input_valid_hold()) begin
      next_state = ST_DONE;
    end
  end

  // done survives a default-mode reload; a fresh supply, an enable write, or supply loss, ce_n set, hiz or overvoltage leaves it
  function automatic logic input_valid_hold();
    input_valid_hold = sn.input_valid & ~ce_n & ~hiz & ~sn.bat_ovp & ~input_rise & ~ce_write0;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= ST_IDLE;
      det_cnt <= '0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        det_cnt <= '0;
      end else if (tick) begin
        det_cnt <= det_cnt + TW'(1);
      end
    end
  end

  // fault reporting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault      <= FLT_NONE;
      nobat_seen <= 1'b0;
    end else begin
      if (state == ST_SINK && !sn.bat_above_detect) begin
        fault      <= FLT_NOBAT;
        nobat_seen <= 1'b1;
      end else if (state == ST_SINK && next_state != ST_SINK && next_state != ST_IDLE) begin
        fault      <= FLT_NONE;
        nobat_seen <= 1'b0;
      end
      if (sn.bat_ovp) begin
        fault <= FLT_OVP;
      end else if (safe_hit) begin
        fault <= FLT_SAFETY;
      end else if (input_rise || (fault == FLT_OVP) || (ce_write0 && fault == FLT_SAFETY)) begin
        fault      <= FLT_NONE;
        nobat_seen <= 1'b0;
      end
    end
  end

  // status and interrupt pulse; a new event restarts the pulse
  assign pulse_req = input_rise | safe_hit | (state == ST_SINK && next_state == ST_SOURCE);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_cnt <= 32'h0000_0000;
    end else if (pulse_req) begin
      pulse_cnt <= 32'(PULSE_CYCLES);
    end else if (pulse_cnt != 32'h0000_0000) begin
      pulse_cnt <= pulse_cnt - 32'h0000_0001;
    end
  end

  // battery-only short retry: switch held off for the deglitch time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_hold <= 1'b0;
      glitch_cnt <= '0;
    end else if (sn.input_valid) begin
      short_hold <= 1'b0;
      glitch_cnt <= '0;
    end else if (!short_hold && sn.short_limit) begin
      short_hold <= 1'b1;
      glitch_cnt <= '0;
    end else if (short_hold && tick) begin
      glitch_cnt <= glitch_cnt + TW'(1);
      if (glitch_cnt >= TW'(DEGLITCH_TICKS - 1)) begin
        short_hold <= 1'b0;
      end
    end
  end

  // pin drives, all registered
  always_comb begin
    next_drive                      = '0;
    next_drive.converter_en         = sn.input_valid & ~hiz & ~sn.bat_ovp;
    next_drive.detect_sink_en       = (state == ST_SINK);
    next_drive.short_source_en      = (state == ST_SOURCE) & ~sn.bat_above_detect;
    next_drive.discharge_gate_drive = ~sn.input_valid | hiz;
    next_drive.stat_int_pulse       = (pulse_cnt != 32'h0000_0000);
    next_drive.default_mode         = default_mode;
    // the limit pin only counts while no host has programmed us
    next_drive.input_limit_high     = default_mode ? ~sn.ilim_pin : ilim;
    if (sn.bat_ovp) begin
      next_drive.battery_switch_on = 1'b1;
    end else if (!sn.input_valid) begin
      next_drive.battery_switch_on = sn.bat_above_uvlo & ~short_hold;
      next_drive.battery_node_hiz  = ~sn.bat_above_uvlo;
    end else begin
      next_drive.battery_switch_on = (state == ST_CHARGE) | (~ce_n & ~hiz & sn.load_at_zero);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive <= '0;
    end else begin
      drive <= next_drive;
    end
  end
endmodule : cst_charge_supervisor

// *** verif/cst_battery_model.sv ***
module cst_battery_model (
  input  wire logic               hclk,
  input  wire cst_pkg::cst_drive_t drive,
  input  wire logic               present,
  output logic                    bat_above_detect
);
  timeunit 1ns;
  timeprecision 1ps;
  import cst_pkg::*;
  int unsigned lift = 0;

  // a missing cell is just the node capacitance: sinking empties it, sourcing lifts it slowly
  always_ff @(posedge hclk) begin
    if (drive.detect_sink_en) begin
      lift <= 0;
    end else if (drive.short_source_en && lift < 3) begin
      lift <= lift + 1;
    end
  end

  // a real cell holds the node up whatever the probe currents do
  assign bat_above_detect = present || (lift >= 3);
endmodule // cst_battery_model

// *** verif/cst_supervisor_props.sv ***
module cst_supervisor_props #(
  parameter int unsigned PULSE_CYCLES = 8
) (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hsel,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                hready,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic [31:0]         hrdata,
  input wire cst_pkg::cst_sense_t sense,
  input wire cst_pkg::cst_drive_t drive
);
  timeunit 1ns;
  timeprecision 1ps;
  import cst_pkg::*;
  int unsigned run;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // length of the running status pulse; restarts stretch it, never shorten it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) run <= 0;
    else run <= drive.stat_int_pulse ? run + 1 : 0;
  end

  sequence s_supply_rise;
    $rose(sense.input_valid);
  endsequence
  sequence s_ilim_held;
    (drive.default_mode && $stable(sense.ilim_pin)) [*6];
  endsequence

  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or errored");
  AST_RDATA_IDLE: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 0)
    else $error("read data not zero outside a read");
  AST_GATE_NO_SUPPLY: assert property (!sense.input_valid [*8] |=> drive.discharge_gate_drive)
    else $error("gate drive off without supply");
  AST_UVLO_HIZ: assert property ((!sense.input_valid && !sense.bat_above_uvlo) [*8]
    |=> !drive.battery_switch_on && drive.battery_node_hiz)
    else $error("weak battery not isolated");
  AST_OVP_DISCHARGE: assert property ((sense.input_valid && sense.bat_ovp) [*8]
    |=> !drive.converter_en && drive.battery_switch_on)
    else $error("overvoltage not handled");
  AST_SUPPLY_PULSE: assert property (s_supply_rise |-> ##[1:8] drive.stat_int_pulse)
    else $error("no pulse on new supply");
  AST_PULSE_LEN: assert property ($fell(drive.stat_int_pulse) |-> run >= PULSE_CYCLES)
    else $error("status pulse too short");
  AST_DEFAULT_ILIM: assert property (s_ilim_held |-> drive.input_limit_high == !sense.ilim_pin)
    else $error("limit pin ignored in default mode");
endmodule // cst_supervisor_props

bind cst_charge_supervisor cst_supervisor_props #(.PULSE_CYCLES(PULSE_CYCLES)) props_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .sense(sense), .drive(drive));

// *** verif/test_charge_supervisor_timers.sv ***
module test_charge_supervisor_timers;
  timeunit 1ns;
  timeprecision 1ps;
  import cst_pkg::*;
  localparam int TK  = 4;
  localparam int WDL = 2000;
  localparam int SFL = 100;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = '0;
  logic [1:0]  htrans  = '0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'b010;
  logic [31:0] hwdata  = '0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        above;
  logic        present = 1'b0;
  cst_sense_t  sv;
  cst_sense_t  sense;
  cst_drive_t  drive;
  int          err_count = 0;
  int          cmp_count = 0;
  int          mdl [8];
  logic [7:0]  msk [8] = '{8'h00, 8'h00, 8'h07, 8'h3F, 8'hF8, 8'h60, 8'h00, 8'h00};
  logic [31:0] xs_state = 32'h0000_0004;
  logic [31:0] rd;
  int          sinks = 0;

  // 50 MHz bus clock
  always #10 hclk = ~hclk;

  // sink phases are short, so count every cycle the probe current is on
  always @(posedge hclk) begin
    if (drive.detect_sink_en) sinks <= sinks + 1;
  end

  // probe-dependent cell level comes from the model, the rest from the bench
  always_comb begin
    sense = sv;
    sense.bat_above_detect = above;
  end

  cst_charge_supervisor #(.TICK_CYCLES(TK), .PULSE_CYCLES(8), .WD_LIMIT(WDL), .SAFE_LIMIT(SFL))
  dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sense(sense), .drive(drive));

  cst_battery_model bat_u (.hclk(hclk), .drive(drive), .present(present),
    .bat_above_detect(above));

  function automatic logic [31:0] xs();
    xs_state ^= xs_state << 13;
    xs_state ^= xs_state >> 17;
    xs_state ^= xs_state << 5;
    return xs_state;
  endfunction

  // expected register contents after reset or a default-mode reload
  task automatic reload();
    mdl = '{default: 0};
    mdl[3] = int'(VREG_DEF);
    mdl[4] = int'({ICHG_DEF, TERM_DEF, 3'b000});
    mdl[5] = int'({SEL_DEF, 5'b00000});
  endtask

  task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic chk_pin(input string nm, input logic exp, input logic got);
    chk_reg(nm, {31'h0000_0000, exp}, {31'h0000_0000, got});
  endtask

  // one single-word transfer; waits on the slave, never on a cycle count
  task automatic xfer(input logic w, input int idx, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= 32'(idx * 4);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    if (w) mdl[idx] = int'(wd & {24'h00_0000, msk[idx]});
  endtask

  task automatic rdchk(input int idx);
    xfer(1'b0, idx, '0);
    chk_reg($sformatf("reg%0d", idx), 32'(mdl[idx]), rd);
  endtask

  // fault code always, state code unless st is negative
  task automatic chk_stat(input int flt, input int st);
    xfer(1'b0, 0, '0);
    chk_reg("fault", 32'(flt), {30'h0000_0000, rd[5:4]});
    if (st >= 0) chk_reg("state", 32'(st), {29'h0000_0000, rd[2:0]});
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard, well beyond the roughly 35k cycles the sequence needs
  initial begin
    repeat (60000) @(posedge hclk);
    err_count++;
    conclude();
  end

  initial begin
    sv = '0;
    sv.bat_above_uvlo = 1'b1;
    reload();
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (10) @(posedge hclk);
    chk_pin("gate", 1'b1, drive.discharge_gate_drive);
    chk_pin("ilim", 1'b1, drive.input_limit_high);
    chk_pin("dflt", 1'b1, drive.default_mode);
    for (int i = 2; i < 7; i++) rdchk(i);
    for (int i = 3; i < 6; i++) xfer(1'b1, i, xs());
    for (int i = 2; i < 6; i++) rdchk(i);
    sv.ilim_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    chk_pin("ilim", 1'b0, drive.input_limit_high);
    chk_pin("dflt", 1'b0, drive.default_mode);
    sv.bat_above_uvlo <= 1'b0;
    repeat (20) @(posedge hclk);
    chk_pin("sw", 1'b0, drive.battery_switch_on);
    chk_pin("hiz", 1'b1, drive.battery_node_hiz);
    sv.bat_above_uvlo <= 1'b1;
    repeat (10) @(posedge hclk);
    chk_pin("sw", 1'b1, drive.battery_switch_on);
    // battery-only short: switch off for the deglitch time, then retried
    sv.short_limit <= 1'b1;
    repeat (10) @(posedge hclk);
    chk_pin("sw", 1'b0, drive.battery_switch_on);
    sv.short_limit <= 1'b0;
    repeat (DEGLITCH_TICKS * TK + 20) @(posedge hclk);
    chk_pin("sw", 1'b1, drive.battery_switch_on);
    // host silent past the timeout: registers fall back to defaults
    repeat (WDL * TK + 50) @(posedge hclk);
    chk_pin("dflt", 1'b1, drive.default_mode);
    reload();
    for (int i = 2; i < 6; i++) rdchk(i);
    xfer(1'b1, 3, 32'h0000_0011);
    repeat (2) begin
      repeat (WDL * TK - 2000) @(posedge hclk);
      xfer(1'b1, 2, 32'h0000_0080);
    end
    rdchk(3);
    rdchk(2);
    // supply arrives with charging allowed
    sv.input_valid <= 1'b1;
    repeat (20) @(posedge hclk);
    chk_pin("gate", 1'b0, drive.discharge_gate_drive);
    xfer(1'b0, 1, '0);
    chk_reg("supply", 32'h0000_0003, rd & 32'h0000_0003);
    chk_stat(0, 1);
    xfer(1'b1, 2, 32'h0000_0001);
    repeat (10) @(posedge hclk);
    chk_pin("gate", 1'b1, drive.discharge_gate_drive);
    xfer(1'b1, 2, 32'h0000_0000);
    repeat (SFL * TK + 200) @(posedge hclk);
    mdl[2] = 2;
    rdchk(2);
    chk_stat(3, -1);
    xfer(1'b1, 5, 32'h0000_0060);
    xfer(1'b1, 2, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    chk_stat(0, 1);
    // termination reached with and without detection enabled
    xfer(1'b1, 4, 32'h0000_0040);
    sv.term_reached <= 1'b1;
    repeat (50) @(posedge hclk);
    chk_stat(0, 1);
    chk_pin("sink", 1'b0, sinks != 0);
    xfer(1'b1, 4, 32'h0000_0048);
    repeat (50) @(posedge hclk);
    chk_pin("sink", 1'b1, sinks != 0);
    repeat (DETECT_TICKS * TK + 100) @(posedge hclk);
    chk_stat(2, 4);
    present <= 1'b1;
    sv.term_reached <= 1'b0;
    repeat (3 * DETECT_TICKS * TK) @(posedge hclk);
    chk_stat(0, 1);
    sv.term_reached <= 1'b1;
    repeat (DETECT_TICKS * TK + 200) @(posedge hclk);
    chk_stat(0, 5);
    // outside the charge state the switch follows the supplement demand
    sv.load_at_zero <= 1'b1;
    repeat (10) @(posedge hclk);
    chk_pin("sw", 1'b1, drive.battery_switch_on);
    sv.load_at_zero <= 1'b0;
    repeat (10) @(posedge hclk);
    chk_pin("sw", 1'b0, drive.battery_switch_on);
    // host silent again: defaults return but a finished charge stays done
    repeat (WDL * TK) @(posedge hclk);
    chk_pin("dflt", 1'b1, drive.default_mode);
    reload();
    rdchk(4);
    chk_stat(0, 5);
    sv.bat_ovp <= 1'b1;
    repeat (20) @(posedge hclk);
    chk_pin("conv", 1'b0, drive.converter_en);
    chk_pin("sw", 1'b1, drive.battery_switch_on);
    chk_stat(1, -1);
    conclude();
  end
endmodule // test_charge_supervisor_timers
